//--- omss_pkg.sv
package omss_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 16;
  localparam int          AREA_N           = 8;
  localparam logic [7:0]  MODE_STATUS_ADDR = 8'h00;

  // ---------------------------------------------------------------
  // mode status field layout
  // ---------------------------------------------------------------
  localparam int          FIELD_HI_MSB     = 10;
  localparam int          FIELD_HI_LSB     = 8;
  localparam int          FIELD_LO_MSB     = 2;
  localparam int          FIELD_LO_LSB     = 0;
  localparam logic [4:0]  FIXED_PATTERN    = 5'h0a;
  localparam logic [2:0]  STAT_UNCAPTURED  = 3'h0;

  // ---------------------------------------------------------------
  // strap patterns and reported codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  STRAP_MODE4      = 3'h4;
  localparam logic [2:0]  STRAP_MODE5      = 3'h5;
  localparam logic [2:0]  CODE_MODE4       = 3'h2;
  localparam logic [2:0]  CODE_MODE5       = 3'h1;
  localparam logic [2:0]  MODE_NUM_4       = 3'h4;
  localparam logic [2:0]  MODE_NUM_5       = 3'h5;
  localparam logic [2:0]  MODE_NUM_NONE    = 3'h0;

  // ---------------------------------------------------------------
  // fixed processor setup
  // ---------------------------------------------------------------
  localparam int          ADDR_SPACE_BITS  = 24;
  localparam logic [4:0]  ADDR_SPACE_W     = 5'h18;

  typedef enum logic {OMSS_BUS8, OMSS_BUS16} omss_width_t;

endpackage

//--- omss_strap_if.sv
`timescale 1ns/1ps
interface omss_strap_if;
  logic [2:0] strap_levels;
  logic       capture;
  logic [2:0] status_code;
  logic       status_valid;

  modport ctrl (output strap_levels, output capture, input status_code, input status_valid);
  modport latch (input strap_levels, input capture, output status_code, output status_valid);
endinterface

//--- omss_strap_latch.sv
`timescale 1ns/1ps
module omss_strap_latch (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // strap path
  omss_strap_if.latch st
);

  typedef struct packed {
    logic [2:0] code;
    logic       valid;
  } omss_latch_t;

  omss_latch_t s_q;
  omss_latch_t s_d;

  always_comb begin
    s_d = s_q;
    // first read after reset wins; later reads keep the held value
    if (st.capture && !s_q.valid) begin
      s_d.code  = st.strap_levels;
      s_d.valid = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st.status_code  = s_q.code;
  assign st.status_valid = s_q.valid;

endmodule

//--- omss_width_sel.sv
`timescale 1ns/1ps
module omss_width_sel #(
  parameter int AREA_N = omss_pkg::AREA_N
) (
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // control
  input  wire logic              run,
  input  wire logic              mode5,
  input  wire logic [AREA_N-1:0] area_16,
  // result
  output logic                   bus16
);

  typedef struct packed {
    logic w16;
  } omss_wsel_t;

  omss_wsel_t s_q;
  omss_wsel_t s_d;
  logic       any16;

  assign any16 = |area_16;

  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d.w16 = !mode5;
    end else begin
      s_d.w16 = any16;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus16 = s_q.w16;

endmodule

//--- omss_top.sv
// How it works
// - the strap pattern 1-0-0 selects mode 4 and 1-0-1 selects mode 5, nothing else is a mode.
// - both modes run advanced addressing over 16 Mbytes with on-chip ROM off.
// - in reset the bus is 8 bits wide and the first cycle after it 16; from then on it is 16 bits in mode 4 and 8 bits in mode 5.
// - once running, any 16-bit area makes the bus 16 bits, all 8-bit areas make it 8.
// - a read of the status register captures the straps into bits 10 to 8.
// - the captured value holds until reset, after which the next read captures again.
// - the field shows 010 for mode 4 and 001 for mode 5.
// - bits 15 to 11 and 7 to 3 read as the fixed pattern 01010 and ignore writes.
// - bits 2 to 0 mirror the reported code in bits 10 to 8 and are read-only.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module omss_top #(
  parameter int AREA_N = omss_pkg::AREA_N
) (
  // clock and reset
  input  wire logic                        CLOCK,
  input  wire logic                        RST,
  // mode straps
  input  wire logic                        MODE_STRAP_2,
  input  wire logic                        MODE_STRAP_1,
  input  wire logic                        MODE_STRAP_0,
  // register port
  input  wire logic [omss_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [omss_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [omss_pkg::DATA_W-1:0] RDATA,
  // bus controller side
  input  wire logic                        RUN,
  input  wire logic [AREA_N-1:0]           AREA_16BIT,
  // mode outputs
  output logic      [2:0]                  MODE_NUM,
  output logic                             MODE_VALID,
  output logic                             ADVANCED_MODE,
  output logic                             ONCHIP_ROM_EN,
  output logic      [4:0]                  ADDR_SPACE_W,
  output logic                             BUS_16BIT
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [omss_pkg::DATA_W-1:0] rdata;
    logic [2:0]                  mode_num;
    logic                        mode_valid;
  } omss_top_t;

  omss_top_t     s_q;
  omss_top_t     s_d;
  omss_strap_if  st ();
  logic [2:0]    straps;
  logic [2:0]    field;
  logic          hit;
  logic          bus16;

  assign straps = {MODE_STRAP_2, MODE_STRAP_1, MODE_STRAP_0};
  assign hit    = (ADDR == omss_pkg::MODE_STATUS_ADDR);

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // write is not wired in at all, so it cannot disturb anything
  assign st.strap_levels = straps;
  assign st.capture      = RD && hit;

  omss_strap_latch u_latch (
    .CLOCK (CLOCK),
    .RST   (RST),
    .st    (st.latch)
  );

  // translate the held strap pattern into the reported code
  always_comb begin
    case (st.status_code)
      omss_pkg::STRAP_MODE4: field = omss_pkg::CODE_MODE4;
      omss_pkg::STRAP_MODE5: field = omss_pkg::CODE_MODE5;
      default:               field = omss_pkg::STAT_UNCAPTURED;
    endcase
  end

  // ---------------------------------------------------------------
  // read path and mode decode
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (RD && hit) begin
      // read returns the pins seen now when nothing is held yet,
      // so the very first read already shows the captured value
      if (st.status_valid) begin
        s_d.rdata = {omss_pkg::FIXED_PATTERN, field,
                     omss_pkg::FIXED_PATTERN, field};
      end else begin
        case (straps)
          omss_pkg::STRAP_MODE4: s_d.rdata = {omss_pkg::FIXED_PATTERN, omss_pkg::CODE_MODE4,
                                              omss_pkg::FIXED_PATTERN, omss_pkg::CODE_MODE4};
          omss_pkg::STRAP_MODE5: s_d.rdata = {omss_pkg::FIXED_PATTERN, omss_pkg::CODE_MODE5,
                                              omss_pkg::FIXED_PATTERN, omss_pkg::CODE_MODE5};
          default:               s_d.rdata = {omss_pkg::FIXED_PATTERN, omss_pkg::STAT_UNCAPTURED,
                                              omss_pkg::FIXED_PATTERN, omss_pkg::STAT_UNCAPTURED};
        endcase
      end
    end
    case (straps)
      omss_pkg::STRAP_MODE4: begin
        s_d.mode_num   = omss_pkg::MODE_NUM_4;
        s_d.mode_valid = 1'b1;
      end
      omss_pkg::STRAP_MODE5: begin
        s_d.mode_num   = omss_pkg::MODE_NUM_5;
        s_d.mode_valid = 1'b1;
      end
      default: begin
        // illegal board strapping: flagged, never treated as a mode
        s_d.mode_num   = omss_pkg::MODE_NUM_NONE;
        s_d.mode_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // bus width
  // ---------------------------------------------------------------
  omss_width_sel #(
    .AREA_N (AREA_N)
  ) u_width (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .run     (RUN),
    .mode5   (s_q.mode_num == omss_pkg::MODE_NUM_5),
    .area_16 (AREA_16BIT),
    .bus16   (bus16)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign RDATA         = s_q.rdata;
  assign MODE_NUM      = s_q.mode_num;
  assign MODE_VALID    = s_q.mode_valid;
  assign ADVANCED_MODE = 1'b1;
  assign ONCHIP_ROM_EN = 1'b0;
  assign ADDR_SPACE_W  = omss_pkg::ADDR_SPACE_W;
  assign BUS_16BIT     = bus16;

endmodule

//--- omss_props.sv
`timescale 1ns/1ps
module omss_props #(
  parameter int AREA_N = 8
) (
  // clock and reset
  input wire logic              CLOCK,
  input wire logic              RST,
  // straps and register port
  input wire logic              MODE_STRAP_2,
  input wire logic              MODE_STRAP_1,
  input wire logic              MODE_STRAP_0,
  input wire logic [7:0]        ADDR,
  input wire logic              RD,
  input wire logic [15:0]       RDATA,
  // width and mode
  input wire logic              RUN,
  input wire logic [AREA_N-1:0] AREA_16BIT,
  input wire logic [2:0]        MODE_NUM,
  input wire logic              MODE_VALID,
  input wire logic              ADVANCED_MODE,
  input wire logic              ONCHIP_ROM_EN,
  input wire logic [4:0]        ADDR_SPACE_W,
  input wire logic              BUS_16BIT
);
  // -----------------------------
  // shadow of the strap capture
  // -----------------------------
  logic [2:0] pins, held_q, src, code;
  logic       cap_q, rd0, any16;
  assign pins  = {MODE_STRAP_2, MODE_STRAP_1, MODE_STRAP_0};
  assign rd0   = RD && ADDR == 8'h00;
  assign any16 = |AREA_16BIT;
  assign src   = cap_q ? held_q : pins;
  assign code  = src == 3'h4 ? 3'h2 : src == 3'h5 ? 3'h1 : 3'h0;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cap_q  <= 1'b0;
      held_q <= 3'h0;
    end else if (rd0 && !cap_q) begin
      cap_q  <= 1'b1;
      held_q <= pins;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // -----------------------------
  // properties
  // -----------------------------
  a_fixed_setup: assert property (ADVANCED_MODE && !ONCHIP_ROM_EN && ADDR_SPACE_W == 5'h18)
    else $error("fixed setup outputs wrong");
  a_mode_track: assert property (!RST |=> MODE_NUM ==
    ($past(pins) == 3'h4 ? 3'h4 : $past(pins) == 3'h5 ? 3'h5 : 3'h0))
    else $error("mode number wrong");
  a_valid_tie: assert property (!RST |=> MODE_VALID ==
    ($past(pins) == 3'h4 || $past(pins) == 3'h5))
    else $error("mode valid wrong");
  a_width_default: assert property (!RST && !RUN |=>
    BUS_16BIT == ($past(MODE_NUM) != 3'h5))
    else $error("default width wrong");
  a_width_run: assert property (!RST && RUN |=> BUS_16BIT == $past(any16))
    else $error("switched width wrong");
  a_field_code: assert property (rd0 |=> RDATA[10:8] == $past(code))
    else $error("status field wrong");
  a_fixed_bits: assert property (rd0 |=> RDATA[15:11] == 5'h0a && RDATA[7:3] == 5'h0a)
    else $error("fixed bits wrong");
  a_low_mirror: assert property (rd0 |=> RDATA[2:0] == $past(code))
    else $error("low bits differ");
  a_quiet_else: assert property (!rd0 |=> RDATA == 16'h0000)
    else $error("read data not idle");
endmodule

//--- omss_strap_board.sv
`timescale 1ns/1ps
module omss_strap_board (
  // chosen pattern
  input  wire logic [2:0] pattern,
  // strap pins
  output logic            mode_strap_2,
  output logic            mode_strap_1,
  output logic            mode_strap_0
);
  // straps are static levels; a bad pattern only when the bench asks
  assign {mode_strap_2, mode_strap_1, mode_strap_0} = pattern;
endmodule

//--- omss_top_tb_top.sv
`timescale 1ns/1ps
module omss_top_tb_top;
  logic        clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, rd_d = 1'b0;
  logic [7:0]  addr = 8'h00, area = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [2:0]  pat = 3'h4, mode_num;
  logic [4:0]  asw;
  logic        st2, st1, st0, mode_valid, adv, rom, bus16;
  logic [31:0] lf = 32'hcf3e;
  logic [15:0] expq[$];
  int          miscompares = 0, tests_run = 0;
  always #2.5 clock = ~clock;
  omss_strap_board i_omss_strap_board (.pattern(pat), .mode_strap_2(st2),
    .mode_strap_1(st1), .mode_strap_0(st0));
  omss_top #(.AREA_N(8)) i_omss_top (.CLOCK(clock), .RST(rst), .MODE_STRAP_2(st2),
    .MODE_STRAP_1(st1), .MODE_STRAP_0(st0), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RUN(run), .AREA_16BIT(area), .MODE_NUM(mode_num),
    .MODE_VALID(mode_valid), .ADVANCED_MODE(adv), .ONCHIP_ROM_EN(rom),
    .ADDR_SPACE_W(asw), .BUS_16BIT(bus16));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] word(input logic [2:0] s);
    logic [2:0] c;
    c = s == 3'h4 ? 3'h2 : s == 3'h5 ? 3'h1 : 3'h0;
    return {5'h0a, c, 5'h0a, c};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one bus cycle; strobes stay as set until the next call
  task op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] e);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= lf[15:0];
    lf = nxt(lf);
    if (r) expq.push_back(e);
    @(posedge clock);
  endtask
  task reset_dut;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // answer stands one cycle after the read, so look mid-cycle
  always @(negedge clock) begin
    if (rd_d && expq.size() == 0) chk(rdata, 16'hxxxx);
    else if (rd_d) chk(rdata, expq.pop_front());
    rd_d = rd;
  end
  initial begin
    reset_dut;
    op(0, 1, 8'h00, word(3'h4));
    op(1, 0, 8'h00, 16'h0000);
    op(0, 1, 8'h00, word(3'h4));
    op(0, 1, 8'h3c, 16'h0000);
    op(0, 0, 8'h00, 16'h0000);
    #1 chk(mode_num, 3'h4);
    chk(bus16, 1'b1);
    chk({adv, rom, asw}, {1'b1, 1'b0, 5'h18});
    @(posedge clock);
    pat <= 3'h5;
    repeat (3) op(0, 0, 8'h00, 16'h0000);
    op(0, 1, 8'h00, word(3'h4));
    op(0, 0, 8'h00, 16'h0000);
    #1 chk(mode_num, 3'h5);
    chk(bus16, 1'b0);
    @(posedge clock);
    reset_dut;
    op(0, 1, 8'h00, word(3'h5));
    op(0, 0, 8'h00, 16'h0000);
    pat <= 3'h7;
    reset_dut;
    op(0, 1, 8'h00, word(3'h7));
    op(0, 0, 8'h00, 16'h0000);
    #1 chk(mode_valid, 1'b0);
    @(posedge clock);
    pat <= 3'h4;
    run <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      area <= i == 0 ? 8'h00 : i == 1 ? 8'h80 : lf[7:0];
      lf = nxt(lf);
      @(posedge clock);
      #1 chk(bus16, |area);
    end
    tally_and_finish;
  end
  // cut a hang short
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    tally_and_finish;
  end
endmodule
bind omss_top omss_props #(.AREA_N(AREA_N)) i_omss_props (.CLOCK(CLOCK), .RST(RST),
  .MODE_STRAP_2(MODE_STRAP_2), .MODE_STRAP_1(MODE_STRAP_1), .MODE_STRAP_0(MODE_STRAP_0),
  .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .RUN(RUN), .AREA_16BIT(AREA_16BIT),
  .MODE_NUM(MODE_NUM), .MODE_VALID(MODE_VALID), .ADVANCED_MODE(ADVANCED_MODE),
  .ONCHIP_ROM_EN(ONCHIP_ROM_EN), .ADDR_SPACE_W(ADDR_SPACE_W), .BUS_16BIT(BUS_16BIT));
